// ==== core/msz_defs.svh ====
// constants of the memory size and programming entry block
// assumes a 50 MHz core clock and 8-bit data space accesses
`ifndef MSZ_DEFS_SVH
`define MSZ_DEFS_SVH
`define MSZ_ADDR_MEM_SIZE 16'hFFF0
`define MSZ_ADDR_XRAM_SIZE 16'hFFF4
`define MSZ_ADDR_HALT_CLK 16'hFF51
`define MSZ_MEM_RST_SMALL 8'hC8
`define MSZ_MEM_RST_MID 8'hCC
`define MSZ_MEM_RST_LARGE 8'hCF
`define MSZ_XRAM_RST_FLASH 8'h08
`define MSZ_XRAM_RST_MASK 8'h0C
`define MSZ_HALT_CLK_RST 8'h08
`define MSZ_MEM_WMASK 8'hEF
`define MSZ_XRAM_WMASK 8'h0F
`define MSZ_HALT_CLK_WMASK 8'h03
`define MSZ_ROM_32K 4'h8
`define MSZ_ROM_48K 4'hC
`define MSZ_ROM_60K 4'hF
`define MSZ_ROM_KB_32 6'h20
`define MSZ_ROM_KB_48 6'h30
`define MSZ_ROM_KB_60 6'h3C
`define MSZ_RAM_1K 3'h6
`define MSZ_XRAM_480 4'hB
`define MSZ_XRAM_2016 4'h8
`define MSZ_XRAM_B_480 11'h1E0
`define MSZ_XRAM_B_2016 11'h7E0
`define MSZ_DIV_BASE_EXP 3'h4
`define MSZ_PULSES_SIO 4'h0
`define MSZ_PULSES_SIO_HS 4'h3
`define MSZ_PULSES_UART 4'h8
`define MSZ_CLK_HZ 50000000
`define MSZ_SETTLE_US 100
`endif

// ==== core/msz_pkg.sv ====
// types of the memory size and programming entry block
// assumes msz_defs.svh for all numeric constants
package msz_pkg;
  typedef enum logic [1:0] {
    MSZ_VAR_SMALL = 2'b00,
    MSZ_VAR_MID = 2'b01,
    MSZ_VAR_LARGE = 2'b10,
    MSZ_VAR_FLASH = 2'b11
  } msz_variant_e;
  typedef enum logic [2:0] {
    MSZ_ST_IDLE = 3'b000,
    MSZ_ST_ARMED = 3'b001,
    MSZ_ST_COUNT = 3'b010,
    MSZ_ST_DONE = 3'b011,
    MSZ_ST_INVALID = 3'b100
  } msz_state_e;
  typedef enum logic [1:0] {
    MSZ_M_NONE = 2'b00,
    MSZ_M_SIO = 2'b01,
    MSZ_M_SIO_HS = 2'b10,
    MSZ_M_UART = 2'b11
  } msz_method_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } msz_bus_s;
endpackage

// ==== core/msz_clkdiv.sv ====
// halt-mode flash clock divider, one-cycle enable output
// assumes run and sel come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "msz_defs.svh"
module msz_clkdiv
  import msz_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick_q
);
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } msz_div_s;
  msz_div_s s_q, s_d;
  logic [6:0] term;
  assign term = 7'((8'h01 << (`MSZ_DIV_BASE_EXP + 3'(sel))) - 8'h01);
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = 7'h00;
    end else if (s_q.cnt >= term) begin
      s_d.cnt = 7'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick_q = s_q.tick;
endmodule // msz_clkdiv
`default_nettype wire

// ==== core/msz_top.sv ====
// memory size registers, halt flash clock and programming entry
// assumes 8-bit data space accesses on bus_req, vpp and reset pins async
// Overview of operation
// - memory size register at FFF0H, resets CFH in large and flash variants
// - rom field: 8=32K, C=48K, F=60K
// - fast ram field 110 means 1024 bytes
// - memory size reset value follows product variant
// - expansion ram register FFF4H, B=480, 8=2016
// - halt clock register FF51H, resets 08H
// - halt flash clock is oscillator over 2^(4+sel)
// - size registers written as whole bytes, halt clock register only bits 1:0
// - programming armed by vpp high during reset
// - after reset, pulse count 0/3/8 picks method
`timescale 1ns/1ns
`default_nettype none
`include "msz_defs.svh"
module msz_top
  import msz_pkg::*;
#(
  parameter msz_variant_e VARIANT = MSZ_VAR_FLASH,
  parameter int SETTLE_CYCLES = `MSZ_SETTLE_US * (`MSZ_CLK_HZ / 1000000)
) (
  input wire logic clock,
  input wire logic reset,
  input wire msz_bus_s bus_req,
  input wire logic halt_mode,
  input wire logic vpp_high,
  input wire logic reset_pin_n,
  output logic [7:0] rdata_q,
  output logic [7:0] internal_memory_size_q,
  output logic [7:0] expansion_ram_size_q,
  output logic [7:0] halt_flash_clock_select_q,
  output logic [5:0] rom_kbytes_q,
  output logic fast_ram_ok_q,
  output logic [10:0] ext_ram_bytes_q,
  output logic flash_tick_q,
  output logic prog_mode_q,
  output msz_method_e method_q,
  output logic method_invalid_q
);
  localparam logic [7:0] MEM_RST = (VARIANT == MSZ_VAR_SMALL) ? `MSZ_MEM_RST_SMALL :
                                   (VARIANT == MSZ_VAR_MID) ? `MSZ_MEM_RST_MID :
                                   `MSZ_MEM_RST_LARGE;
  localparam logic [7:0] XRAM_RST = (VARIANT == MSZ_VAR_FLASH) ? `MSZ_XRAM_RST_FLASH :
                                    `MSZ_XRAM_RST_MASK;
  localparam logic [16:0] SETTLE_N = 17'(SETTLE_CYCLES);

  typedef struct packed {
    logic [7:0] mem;
    logic [7:0] xram;
    logic [7:0] hclk;
    logic [7:0] rdata;
    logic [5:0] rom_kb;
    logic ram_ok;
    logic [10:0] xram_b;
    logic vpp_s1;
    logic vpp_s2;
    logic vpp_prev;
    logic rst_s1;
    logic rst_s2;
    msz_state_e st;
    logic [3:0] pulses;
    logic [16:0] settle;
    logic prog;
    msz_method_e method;
    logic invalid;
  } msz_state_s;

  msz_state_s s_q, s_d;
  logic rst_active;
  logic vpp_rise;
  logic vpp_edge;

  assign rst_active = !s_q.rst_s2;
  assign vpp_rise = s_q.vpp_s2 && !s_q.vpp_prev;
  assign vpp_edge = s_q.vpp_s2 != s_q.vpp_prev;

  always_comb begin
    s_d = s_q;
    s_d.vpp_s1 = vpp_high;
    s_d.vpp_s2 = s_q.vpp_s1;
    s_d.vpp_prev = s_q.vpp_s2;
    s_d.rst_s1 = reset_pin_n;
    s_d.rst_s2 = s_q.rst_s1;
    // whole-byte writes, fixed-zero bits masked; halt clock writes only bits 1:0 and keeps the rest
    if (bus_req.wr) begin
      if (bus_req.addr == `MSZ_ADDR_MEM_SIZE) begin
        s_d.mem = bus_req.wdata & `MSZ_MEM_WMASK;
      end else if (bus_req.addr == `MSZ_ADDR_XRAM_SIZE) begin
        s_d.xram = bus_req.wdata & `MSZ_XRAM_WMASK;
      end else if (bus_req.addr == `MSZ_ADDR_HALT_CLK) begin
        s_d.hclk = (s_q.hclk & ~`MSZ_HALT_CLK_WMASK) | (bus_req.wdata & `MSZ_HALT_CLK_WMASK);
      end
    end
    s_d.rdata = 8'h00;
    if (bus_req.rd) begin
      if (bus_req.addr == `MSZ_ADDR_MEM_SIZE) begin
        s_d.rdata = s_q.mem;
      end else if (bus_req.addr == `MSZ_ADDR_XRAM_SIZE) begin
        s_d.rdata = s_q.xram;
      end else if (bus_req.addr == `MSZ_ADDR_HALT_CLK) begin
        s_d.rdata = s_q.hclk;
      end
    end
    // size decode, zero marks a prohibited code
    case (s_q.mem[3:0])
      `MSZ_ROM_32K: s_d.rom_kb = `MSZ_ROM_KB_32;
      `MSZ_ROM_48K: s_d.rom_kb = `MSZ_ROM_KB_48;
      `MSZ_ROM_60K: s_d.rom_kb = `MSZ_ROM_KB_60;
      default: s_d.rom_kb = 6'h00;
    endcase
    s_d.ram_ok = s_q.mem[7:5] == `MSZ_RAM_1K;
    case (s_q.xram[3:0])
      `MSZ_XRAM_480: s_d.xram_b = `MSZ_XRAM_B_480;
      `MSZ_XRAM_2016: s_d.xram_b = `MSZ_XRAM_B_2016;
      default: s_d.xram_b = 11'h000;
    endcase
    // programming entry sequencer
    case (s_q.st)
      MSZ_ST_IDLE: begin
        if (rst_active && s_q.vpp_s2) begin
          s_d.st = MSZ_ST_ARMED;
        end
      end
      MSZ_ST_ARMED: begin
        if (!s_q.vpp_s2) begin
          s_d.st = MSZ_ST_IDLE;
        end else if (!rst_active) begin
          s_d.st = MSZ_ST_COUNT;
          s_d.pulses = 4'h0;
          s_d.settle = 17'h00000;
        end
      end
      MSZ_ST_COUNT: begin
        if (rst_active) begin
          s_d.st = MSZ_ST_IDLE;
        end else begin
          if (vpp_rise && s_q.pulses != 4'hF) begin
            s_d.pulses = s_q.pulses + 4'h1;
          end
          if (vpp_edge) begin
            s_d.settle = 17'h00000;
          end else if (s_q.settle < SETTLE_N) begin
            s_d.settle = s_q.settle + 17'h00001;
          end else if (s_q.vpp_s2) begin
            s_d.st = MSZ_ST_DONE;
            case (s_q.pulses)
              `MSZ_PULSES_SIO: s_d.method = MSZ_M_SIO;
              `MSZ_PULSES_SIO_HS: s_d.method = MSZ_M_SIO_HS;
              `MSZ_PULSES_UART: s_d.method = MSZ_M_UART;
              default: s_d.st = MSZ_ST_INVALID;
            endcase
          end
        end
      end
      MSZ_ST_DONE, MSZ_ST_INVALID: begin
        if (rst_active) begin
          s_d.st = MSZ_ST_IDLE;
        end
      end
      default: s_d.st = MSZ_ST_IDLE;
    endcase
    if (s_d.st == MSZ_ST_IDLE) begin
      s_d.method = MSZ_M_NONE;
    end
    s_d.prog = s_d.st inside {MSZ_ST_ARMED, MSZ_ST_COUNT, MSZ_ST_DONE};
    s_d.invalid = s_d.st == MSZ_ST_INVALID;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
      s_q.mem <= MEM_RST;
      s_q.xram <= XRAM_RST;
      s_q.hclk <= `MSZ_HALT_CLK_RST;
      s_q.st <= MSZ_ST_IDLE;
      s_q.method <= MSZ_M_NONE;
      s_q.rst_s1 <= 1'b1;
      s_q.rst_s2 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  msz_clkdiv u_div (
    .clock(clock),
    .reset(reset),
    .run(halt_mode),
    .sel(s_q.hclk[1:0]),
    .tick_q(flash_tick_q)
  );

  assign rdata_q = s_q.rdata;
  assign internal_memory_size_q = s_q.mem;
  assign expansion_ram_size_q = s_q.xram;
  assign halt_flash_clock_select_q = s_q.hclk;
  assign rom_kbytes_q = s_q.rom_kb;
  assign fast_ram_ok_q = s_q.ram_ok;
  assign ext_ram_bytes_q = s_q.xram_b;
  assign prog_mode_q = s_q.prog;
  assign method_q = s_q.method;
  assign method_invalid_q = s_q.invalid;

  default clocking cb @(posedge clock); endclocking

  mem_reset_a: assert property (reset |=> internal_memory_size_q == MEM_RST)
    else $error("memory size reset value wrong");
  xram_reset_a: assert property (reset |=> expansion_ram_size_q == XRAM_RST)
    else $error("expansion ram reset value wrong");
  hclk_reset_a: assert property (reset |=> halt_flash_clock_select_q == `MSZ_HALT_CLK_RST)
    else $error("halt clock register reset value wrong");
  mem_write_a: assert property (disable iff (reset)
    bus_req.wr && bus_req.addr == `MSZ_ADDR_MEM_SIZE
    |=> internal_memory_size_q == ($past(bus_req.wdata) & `MSZ_MEM_WMASK))
    else $error("memory size write lost");
  rom_decode_a: assert property (disable iff (reset)
    internal_memory_size_q[3:0] == `MSZ_ROM_48K |=> rom_kbytes_q == `MSZ_ROM_KB_48)
    else $error("rom size decode wrong");
  ram_decode_a: assert property (disable iff (reset)
    internal_memory_size_q[7:5] != `MSZ_RAM_1K |=> !fast_ram_ok_q)
    else $error("prohibited fast ram code accepted");
  xram_decode_a: assert property (disable iff (reset)
    expansion_ram_size_q[3:0] == `MSZ_XRAM_480 |=> ext_ram_bytes_q == `MSZ_XRAM_B_480 && expansion_ram_size_q[7:4] == 4'h0)
    else $error("expansion ram decode wrong");
  div_period_a: assert property (disable iff (reset || !halt_mode || bus_req.wr)
    flash_tick_q && halt_flash_clock_select_q[1:0] == 2'b00 |-> ##16 flash_tick_q)
    else $error("halt flash clock period wrong");
  arm_cause_a: assert property (disable iff (reset)
    $rose(prog_mode_q) |-> $past(s_q.vpp_s2) && $past(rst_active))
    else $error("programming armed without vpp during reset");
  method_pick_a: assert property (disable iff (reset)
    s_q.st == MSZ_ST_COUNT && s_d.st == MSZ_ST_DONE && s_q.pulses == `MSZ_PULSES_UART |=> method_q == MSZ_M_UART)
    else $error("uart method not selected");
  invalid_pick_a: assert property (disable iff (reset)
    method_invalid_q |-> method_q == MSZ_M_NONE && !prog_mode_q)
    else $error("invalid count entered a method");

  uart_entry_c: cover property (disable iff (reset) $rose(method_q == MSZ_M_UART));
  hs_entry_c: cover property (disable iff (reset) $rose(method_q == MSZ_M_SIO_HS));
  invalid_c: cover property (disable iff (reset) $rose(method_invalid_q));
endmodule // msz_top
`default_nettype wire

// ==== verification/msz_prog_tool.sv ====
// programming tool model driving the vpp detect and reset pins
// assumes the testbench calls its tasks at falling clock edges
`timescale 1ns/1ns
`default_nettype none
module msz_prog_tool
  import msz_pkg::*;
(
  input wire logic clock,
  output logic vpp_high,
  output logic reset_pin_n
);
  initial begin
    vpp_high = 1'b0;
    reset_pin_n = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask
  // vpp raised under reset, reset released, then n pulses
  task automatic enter(input bit use_vpp, input int n);
    reset_pin_n = 1'b0;
    vpp_high = use_vpp;
    hold(8);
    reset_pin_n = 1'b1;
    hold(6);
    repeat (n) begin
      vpp_high = 1'b0;
      hold(4);
      vpp_high = 1'b1;
      hold(4);
    end
  endtask
  task automatic leave();
    reset_pin_n = 1'b0;
    vpp_high = 1'b0;
    hold(6);
    reset_pin_n = 1'b1;
    hold(4);
  endtask
endmodule // msz_prog_tool
`default_nettype wire

// ==== verification/tb_top.sv ====
// testbench of the memory size registers, halt clock and programming entry
// assumes msz_top with a short settle time and the tool model beside it
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import msz_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  msz_bus_s bus = '0;
  logic halt_mode = 1'b0;
  wire vpp_high;
  wire reset_pin_n;
  logic [7:0] rdata_q, mem_q, xram_q, hclk_q;
  logic [7:0] mem_mid_q, xram_mid_q;
  logic [5:0] rom_kb;
  logic [10:0] ext_b;
  logic fast_ok, tick, prog, invalid;
  msz_method_e method;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // 50 MHz, above the uart minimum
  always #10 clock = ~clock;
  msz_top #(.VARIANT(MSZ_VAR_FLASH), .SETTLE_CYCLES(20)) i_msz_top (
    .clock(clock), .reset(reset), .bus_req(bus), .halt_mode(halt_mode), .vpp_high(vpp_high),
    .reset_pin_n(reset_pin_n), .rdata_q(rdata_q), .internal_memory_size_q(mem_q),
    .expansion_ram_size_q(xram_q), .halt_flash_clock_select_q(hclk_q), .rom_kbytes_q(rom_kb),
    .fast_ram_ok_q(fast_ok), .ext_ram_bytes_q(ext_b), .flash_tick_q(tick), .prog_mode_q(prog),
    .method_q(method), .method_invalid_q(invalid));
  msz_prog_tool i_msz_prog_tool (.clock(clock), .vpp_high(vpp_high), .reset_pin_n(reset_pin_n));
  // mask-rom variant, only its reset values are looked at
  msz_top #(.VARIANT(MSZ_VAR_MID), .SETTLE_CYCLES(20)) i_msz_top_mid (
    .clock(clock), .reset(reset), .bus_req(bus), .halt_mode(halt_mode), .vpp_high(vpp_high),
    .reset_pin_n(reset_pin_n), .rdata_q(), .internal_memory_size_q(mem_mid_q),
    .expansion_ram_size_q(xram_mid_q), .halt_flash_clock_select_q(), .rom_kbytes_q(),
    .fast_ram_ok_q(), .ext_ram_bytes_q(), .flash_tick_q(), .prog_mode_q(),
    .method_q(), .method_invalid_q());
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(negedge clock);
    bus.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus.rd = 1'b1;
    bus.addr = a;
    @(negedge clock);
    bus.rd = 1'b0;
    check(16'(rdata_q), 16'(e));
    // idle cycle so back-to-back reads never retoggle rd in one step
    @(negedge clock);
  endtask
  task automatic reg_case(input logic [15:0] a, input logic [7:0] w, input logic [7:0] r);
    wr(a, w);
    rd(a, r);
    @(negedge clock);
  endtask
  task automatic prog_case(input bit v, input int n, input msz_method_e m, input logic inv);
    i_msz_prog_tool.enter(v, n);
    repeat (30) @(negedge clock);
    check(16'(method), 16'(m));
    check(16'(invalid), 16'(inv));
    check(16'(prog), 16'(v && !inv));
    i_msz_prog_tool.leave();
    check(16'(method), 16'(MSZ_M_NONE));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    int k;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
    check(16'(mem_q), 16'h00CF);
    check(16'(xram_q), 16'h0008);
    check(16'(hclk_q), 16'h0008);
    check(16'(mem_mid_q), 16'h00CC);
    check(16'(xram_mid_q), 16'h000C);
    rd(16'hFFF0, 8'hCF);
    rd(16'hFFF4, 8'h08);
    rd(16'hFF51, 8'h08);
    check(16'(rom_kb), 16'h003C);
    check(16'(fast_ok), 16'h0001);
    check(16'(ext_b), 16'h07E0);
    $display("test reset values done");
    reg_case(16'hFFF0, 8'hFF, 8'hEF);
    check(16'(rom_kb), 16'h003C);
    check(16'(fast_ok), 16'h0000);
    reg_case(16'hFFF0, 8'hC8, 8'hC8);
    check(16'(rom_kb), 16'h0020);
    check(16'(fast_ok), 16'h0001);
    reg_case(16'hFFF0, 8'hCC, 8'hCC);
    check(16'(rom_kb), 16'h0030);
    reg_case(16'hFFF0, 8'hC5, 8'hC5);
    check(16'(rom_kb), 16'h0000);
    reg_case(16'hFFF4, 8'hFB, 8'h0B);
    check(16'(ext_b), 16'h01E0);
    reg_case(16'hFFF4, 8'h0C, 8'h0C);
    check(16'(ext_b), 16'h0000);
    reg_case(16'hFFF4, 8'h08, 8'h08);
    check(16'(ext_b), 16'h07E0);
    reg_case(16'hFF51, 8'hFF, 8'h0B);
    reg_case(16'hFF51, 8'h00, 8'h08);
    reg_case(16'hFFF2, 8'h55, 8'h00);
    rd(16'hFFF0, 8'hC5);
    $display("test register access done");
    for (int s = 0; s < 4; s++) begin
      wr(16'hFF51, 8'(s));
      halt_mode = 1'b1;
      k = 0;
      while (tick !== 1'b1 && k < 300) begin
        @(negedge clock);
        k++;
      end
      @(negedge clock);
      k = 1;
      while (tick !== 1'b1 && k < 300) begin
        @(negedge clock);
        k++;
      end
      check(16'(k), 16'(1 << (4 + s)));
      halt_mode = 1'b0;
      @(negedge clock);
    end
    $display("test halt clock done");
    prog_case(1'b0, 0, MSZ_M_NONE, 1'b0);
    prog_case(1'b1, 0, MSZ_M_SIO, 1'b0);
    prog_case(1'b1, 3, MSZ_M_SIO_HS, 1'b0);
    prog_case(1'b1, 8, MSZ_M_UART, 1'b0);
    prog_case(1'b1, 5, MSZ_M_NONE, 1'b1);
    $display("test programming entry done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
